// file: hw/six_bit_updown_counter.v
// six-bit presettable cascadable up/down counter with an axi4-lite view
//
// Functional notes
// - six-bit count changes only on rising clock edge while clear is low
// - both mode selects low loads preset inputs, carry enable ignored
// - select a low, b high, carry enable low: count up by one
// - select a high, b low, carry enable low: count down by one
// - clear high forces count low regardless of clock, mode and inputs
// - clear acts asynchronously, without waiting for a clock edge
// - lookahead carry out low one period, one step before terminal count
// - carry out n low, carry out high, one period when count reaches terminal count with lookahead carry in low
// - both carry outputs come from flip-flops, so they never glitch
// - active-low lookahead carry in and out allow chaining stages
// - an undriven input is taken as a low level
// - clear sets carry out, lookahead out and lookahead in flops high
// - preset drives both carries high; loading terminal value gives no pulse
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "counter_consts.vh"

module six_bit_updown_counter (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire                 async_clear,
  input  wire                 mode_select_a,
  input  wire                 mode_select_b,
  input  wire                 carry_enable_n,
  input  wire                 lookahead_carry_in_n,
  input  wire [`CNT_W-1:0]    preset_inputs,
  output reg  [`CNT_W-1:0]    count_outputs,
  output reg                  carry_out_n,
  output wire                 carry_out,
  output reg                  lookahead_carry_out_n,
  input  wire [`ADDR_W-1:0]   s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [`DATA_W-1:0]   s_axi_wdata,
  input  wire [`STRB_W-1:0]   s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [`ADDR_W-1:0]   s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output reg  [`DATA_W-1:0]   s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready
);

  // ****************************************
  // terminal-count decode
  // ****************************************

  // terminal is all ones going up, all zeros going down
  function is_terminal;
    input [`CNT_W-1:0] value;
    input              up;
    begin
      if (up) begin
        is_terminal = (value == `CNT_ONES);
      end else begin
        is_terminal = (value == `CNT_ZERO);
      end
    end
  endfunction

  // word-aligned compare of a bus address against a register offset
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] offset;
    begin
      addr_hit = ((addr & `WORD_MASK) == offset);
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  reg                 freeze;
  reg                 lookahead_in_q;
  reg  [`EVT_W-1:0]   events;
  reg  [`CNT_W-1:0]   next_count;
  reg                 next_carry_out_n;
  reg                 next_lookahead_out_n;
  reg  [`CNT_W-1:0]   ahead_value;
  reg                 aw_held;
  reg  [`ADDR_W-1:0]  aw_addr;
  reg                 w_held;
  reg  [`DATA_W-1:0]  w_data;
  reg  [`STRB_W-1:0]  w_strb;
  wire [1:0]          mode;
  wire                step_en;
  wire                stepping;
  wire                going_up;
  wire                do_write;
  wire                evt_hit;
  wire                evt_clear;
  wire                wr_ctrl;
  wire                wr_events;
  wire                wr_mapped;
  wire                rd_ctrl;
  wire                rd_status;
  wire                rd_events;

  // ****************************************
  // mode decode
  // ****************************************

  // every inactive or benign level is low, so an open pin reads as preset/count
  assign mode     = {mode_select_a, mode_select_b};
  // freeze is a software-only extra hold; it never blocks preset
  assign step_en  = ~carry_enable_n & ~freeze;
  assign going_up = (mode == `MODE_UP);
  assign stepping = step_en & ((mode == `MODE_UP) | (mode == `MODE_DOWN));
  assign carry_out = ~carry_out_n;

  // ****************************************
  // next count
  // ****************************************

  // preset ignores carry enable; hold covers both selects high
  always @* begin
    case (mode)
      `MODE_PRESET: begin
        next_count = preset_inputs;
      end
      `MODE_UP: begin
        if (step_en) begin
          next_count = count_outputs + `CNT_STEP;
        end else begin
          next_count = count_outputs;
        end
      end
      `MODE_DOWN: begin
        if (step_en) begin
          next_count = count_outputs - `CNT_STEP;
        end else begin
          next_count = count_outputs;
        end
      end
      default: begin
        next_count = count_outputs;
      end
    endcase
  end

  // ****************************************
  // carry prediction
  // ****************************************

  // carries are worked out from the next count so the flop lands with the
  // count itself; a loaded terminal value never pulses because stepping is 0
  always @* begin
    if (going_up) begin
      ahead_value = next_count + `CNT_STEP;
    end else begin
      ahead_value = next_count - `CNT_STEP;
    end
    next_carry_out_n     = 1'b1;
    next_lookahead_out_n = 1'b1;
    if (stepping) begin
      // carry out waits for the lower stages via lookahead in
      if (~lookahead_in_q && is_terminal(next_count, going_up)) begin
        next_carry_out_n = 1'b0;
      end
      if (is_terminal(ahead_value, going_up)) begin
        next_lookahead_out_n = 1'b0;
      end
    end
  end

  // ****************************************
  // counter and carry flops
  // ****************************************

  // clear wins without the clock; aresetn gives the same state synchronously
  always @(posedge aclk or posedge async_clear) begin
    if (async_clear) begin
      count_outputs <= `CNT_ZERO;
    end else if (!aresetn) begin
      count_outputs <= `CNT_ZERO;
    end else begin
      count_outputs <= next_count;
    end
  end

  // carry flop: registered so the pulse never glitches, idles high after clear
  always @(posedge aclk or posedge async_clear) begin
    if (async_clear) begin
      carry_out_n <= 1'b1;
    end else if (!aresetn) begin
      carry_out_n <= 1'b1;
    end else begin
      carry_out_n <= next_carry_out_n;
    end
  end

  // lookahead out flop, cleared with the carry so a chain restarts quiet
  always @(posedge aclk or posedge async_clear) begin
    if (async_clear) begin
      lookahead_carry_out_n <= 1'b1;
    end else if (!aresetn) begin
      lookahead_carry_out_n <= 1'b1;
    end else begin
      lookahead_carry_out_n <= next_lookahead_out_n;
    end
  end

  // lookahead in is held one edge; it reads inactive after clear, so the
  // first step after a clear cannot raise a carry from a stale input
  always @(posedge aclk or posedge async_clear) begin
    if (async_clear) begin
      lookahead_in_q <= 1'b1;
    end else if (!aresetn) begin
      lookahead_in_q <= 1'b1;
    end else begin
      lookahead_in_q <= lookahead_carry_in_n;
    end
  end

  // ****************************************
  // register select
  // ****************************************

  // decoded once so the write and read paths agree on the map
  assign wr_ctrl   = addr_hit(aw_addr, `OFF_CTRL);
  assign wr_events = addr_hit(aw_addr, `OFF_EVENTS);
  assign wr_mapped = wr_ctrl | wr_events | addr_hit(aw_addr, `OFF_STATUS);
  // read decode uses the live address, valid only with the handshake
  assign rd_ctrl   = addr_hit(s_axi_araddr, `OFF_CTRL);
  assign rd_status = addr_hit(s_axi_araddr, `OFF_STATUS);
  assign rd_events = addr_hit(s_axi_araddr, `OFF_EVENTS);

  // ****************************************
  // axi4-lite write path
  // ****************************************

  // address and data are taken in either order, one write at a time
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign do_write      = aw_held & w_held & ~s_axi_bvalid;

  // capture address and data halves
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= `DATA_ZERO;
      w_held  <= 1'b0;
      w_data  <= `DATA_ZERO;
      w_strb  <= {`STRB_W{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // software freeze; only the low strobe lane reaches it
  always @(posedge aclk) begin
    if (!aresetn) begin
      freeze <= `CTRL_RESET;
    end else if (do_write && wr_ctrl && w_strb[0]) begin
      freeze <= w_data[`CTRL_FREEZE];
    end
  end

  // write response: unmapped words are refused, the rest answered okay
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (wr_mapped) begin
          s_axi_bresp <= `RESP_OKAY; // status is read-only, events clear on write
        end else begin
          s_axi_bresp <= `RESP_DECERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // terminal-count event counter
  // ****************************************

  // a pulse in the clearing cycle is kept: the set wins over the clear
  assign evt_hit   = ~carry_out_n;
  assign evt_clear = do_write & wr_events;

  always @(posedge aclk) begin
    if (!aresetn) begin
      events <= `EVT_ZERO;
    end else if (evt_clear) begin
      events <= evt_hit ? `EVT_ONE : `EVT_ZERO;
    end else if (evt_hit) begin
      events <= events + `EVT_ONE; // wraps silently past all ones
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************

  // one read in flight; data is sampled at the address handshake
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `DATA_ZERO;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= `DATA_ZERO;
      s_axi_rresp  <= `RESP_OKAY;
      if (rd_ctrl) begin
        s_axi_rdata[`CTRL_FREEZE] <= freeze;
      end else if (rd_status) begin
        s_axi_rdata[`ST_COUNT_HI:`ST_COUNT_LO] <= count_outputs;
        s_axi_rdata[`ST_CARRY_OUT_N]                  <= carry_out_n;
        s_axi_rdata[`ST_LOOKAHEAD_CARRY_OUT_N]                 <= lookahead_carry_out_n;
        s_axi_rdata[`ST_LOOKAHEAD_CARRY_IN_N]                  <= lookahead_in_q;
        s_axi_rdata[`ST_MODE_HI:`ST_MODE_LO]   <= mode;
      end else if (rd_events) begin
        s_axi_rdata[`EVT_W-1:0] <= events;
      end else begin
        s_axi_rresp <= `RESP_DECERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: hw/counter_consts.vh
// constants shared by the six-bit up/down counter and its register slave
`ifndef COUNTER_CONSTS_VH
`define COUNTER_CONSTS_VH

// ****************************************
// counter datapath
// ****************************************
`define CNT_W          6
`define CNT_ONES       6'h3f
`define CNT_ZERO       6'h00
`define CNT_STEP       6'h01

// mode code is {mode_select_a, mode_select_b}
`define MODE_PRESET    2'b00
`define MODE_UP        2'b01
`define MODE_DOWN      2'b10
`define MODE_HOLD      2'b11

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_W         32
`define DATA_W         32
`define STRB_W         4
`define OFF_CTRL       32'h00000000
`define OFF_STATUS     32'h00000004
`define OFF_EVENTS     32'h00000008
`define WORD_MASK      32'hfffffffc

// ctrl fields
`define CTRL_FREEZE    0
`define CTRL_RESET     1'b0

// status fields
`define ST_COUNT_LO    0
`define ST_COUNT_HI    5
`define ST_CARRY_OUT_N        8
`define ST_LOOKAHEAD_CARRY_OUT_N       9
`define ST_LOOKAHEAD_CARRY_IN_N        10
`define ST_MODE_LO     12
`define ST_MODE_HI     13

// event counter
`define EVT_W          16
`define EVT_ZERO       16'h0000
`define EVT_ONE        16'h0001

// axi responses
`define RESP_OKAY      2'b00
`define RESP_DECERR    2'b11
`define DATA_ZERO      32'h00000000

`endif

// file: sim/counter_asserts.sv
// concurrent checks on the counter pins of the six-bit up/down counter
`timescale 1ns/1ns
`include "counter_consts.vh"
module counter_asserts (
  input wire              aclk,
  input wire              aresetn,
  input wire              async_clear,
  input wire              mode_select_a,
  input wire              mode_select_b,
  input wire              carry_enable_n,
  input wire              lookahead_carry_in_n,
  input wire [`CNT_W-1:0] preset_inputs,
  input wire [`CNT_W-1:0] count_outputs,
  input wire              carry_out_n,
  input wire              carry_out,
  input wire              lookahead_carry_out_n
);
  // ****************************************
  // mode decode and default clocking
  // ****************************************
  wire [1:0] m = {mode_select_a, mode_select_b};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || async_clear);
  // ****************************************
  // stepping
  // ****************************************
  // freeze may hold a step, so a held count is allowed in up and down
  a_preset_load: assert property (m == `MODE_PRESET |=> count_outputs == $past(preset_inputs))
    else $error("preset not loaded");
  a_up_step: assert property (m == `MODE_UP && !carry_enable_n |=> $stable(count_outputs)
    || count_outputs == $past(count_outputs) + `CNT_STEP) else $error("bad up step");
  a_down_step: assert property (m == `MODE_DOWN && !carry_enable_n |=> $stable(count_outputs)
    || count_outputs == $past(count_outputs) - `CNT_STEP) else $error("bad down step");
  a_hold_count: assert property (m == `MODE_HOLD || (carry_enable_n && m != `MODE_PRESET)
    |=> $stable(count_outputs)) else $error("count moved in hold");
  // ****************************************
  // carries
  // ****************************************
  a_ahead_cause: assert property (!lookahead_carry_out_n |->
    ($past(m) == `MODE_UP && count_outputs == 6'h3e)
    || ($past(m) == `MODE_DOWN && count_outputs == `CNT_STEP)) else $error("stray ahead pulse");
  a_ahead_once: assert property (!lookahead_carry_out_n |=> lookahead_carry_out_n)
    else $error("ahead pulse too long");
  a_carry_cause: assert property (!carry_out_n |-> !$past(lookahead_carry_in_n, 2)
    && (($past(m) == `MODE_UP && count_outputs == `CNT_ONES)
    || ($past(m) == `MODE_DOWN && count_outputs == `CNT_ZERO))) else $error("stray carry");
  a_carry_once: assert property (!carry_out_n |=> carry_out_n)
    else $error("carry pulse too long");
  a_carry_pair: assert property (carry_out == !carry_out_n)
    else $error("carry pair not complementary");
  a_preset_quiet: assert property (m == `MODE_PRESET |=> carry_out_n && lookahead_carry_out_n)
    else $error("carry low after preset");
  a_clear_force: assert property (disable iff (!aresetn) async_clear |->
    count_outputs == `CNT_ZERO && carry_out_n && lookahead_carry_out_n) else $error("clear failed");
endmodule

// file: sim/lower_stage.sv
// model of the next lower counter stage driving the cascade inputs
`timescale 1ns/1ns
module lower_stage (
  input  wire aclk,
  input  wire en,
  output reg  carry_n = 1'b1,
  output reg  ahead_n = 1'b1
);
  reg  [5:0] cnt = 6'h00;
  wire [5:0] next_cnt = cnt + 6'h01;
  // restarts from zero when disabled so the chain starts aligned
  always @(posedge aclk) begin
    cnt     <= en ? next_cnt : 6'h00;
    ahead_n <= !(en && next_cnt == 6'h3e);
    carry_n <= !(en && next_cnt == 6'h3f);
  end
endmodule

// file: sim/six_bit_updown_counter_tb_top.sv
// self-checking bench for the six-bit up/down counter
`timescale 1ns/1ns
`include "counter_consts.vh"
module six_bit_updown_counter_tb_top;
  reg         aclk = 1'b0, aresetn = 1'b0, async_clear = 1'b0, chain = 1'b0;
  reg         mode_select_a = 1'b1, mode_select_b = 1'b1, ce_n = 1'b1, lin_n = 1'b1;
  reg  [5:0]  preset_inputs = 6'h00, held;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, rd;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg  [1:0]  resp;
  wire [3:0]  s_axi_wstrb = 4'hf;
  wire [5:0]  count_outputs;
  wire [31:0] s_axi_rdata;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire        carry_out_n, carry_out, lookahead_carry_out_n, p_carry_n, p_ahead_n;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  // the cascade inputs come from the lower stage only while chained
  wire        carry_enable_n = chain ? p_carry_n : ce_n;
  wire        lookahead_carry_in_n = chain ? p_ahead_n : lin_n;
  integer     n_errors = 0, n_tests = 0;

  initial forever #2 aclk = ~aclk;

  six_bit_updown_counter dut (.aclk, .aresetn, .async_clear, .mode_select_a, .mode_select_b,
    .carry_enable_n, .lookahead_carry_in_n, .preset_inputs, .count_outputs, .carry_out_n,
    .carry_out, .lookahead_carry_out_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lower_stage low (.aclk(aclk), .en(chain), .carry_n(p_carry_n), .ahead_n(p_ahead_n));

  // ****************************************
  // helpers
  // ****************************************
  task chk(input [255:0] what, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // reads after an edge show the state left by the edge before it
  task t(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task drv(input [1:0] m, input c, input l, input [5:0] d);
    begin
      {mode_select_a, mode_select_b} <= m;
      ce_n <= c;
      lin_n <= l;
      preset_inputs <= d;
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    reg aw, w;
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      {aw, w} = 2'b11;
      while (aw || w) begin
        @(posedge aclk);
        if (s_axi_awready) aw = 1'b0;
        if (s_axi_wready) w = 1'b0;
        s_axi_awvalid <= aw;
        s_axi_wvalid <= w;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd_reg(input [31:0] a);
    begin
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    t(16);
    aresetn <= 1'b1;
    t(1);
    chk("reset", {count_outputs, carry_out_n, carry_out, lookahead_carry_out_n}, 9'h005);
    $display("reset test done");
    drv(`MODE_PRESET, 1'b1, 1'b0, 6'h3d);
    t(1);
    drv(`MODE_UP, 1'b0, 1'b0, 6'h00);
    t(1);
    chk("preset", count_outputs, 6'h3d);
    t(1);
    chk("up ahead", {count_outputs, lookahead_carry_out_n}, 7'h7c);
    t(1);
    chk("top carry", {count_outputs, carry_out_n, carry_out, lookahead_carry_out_n}, 9'h1fb);
    t(1);
    chk("wrap up", {count_outputs, carry_out_n}, 7'h01);
    drv(`MODE_PRESET, 1'b1, 1'b0, 6'h02);
    t(1);
    drv(`MODE_DOWN, 1'b0, 1'b0, 6'h00);
    t(2);
    chk("down ahead", {count_outputs, lookahead_carry_out_n}, 7'h02);
    t(1);
    chk("bottom carry", {count_outputs, carry_out_n}, 7'h00);
    t(1);
    chk("wrap down", count_outputs, `CNT_ONES);
    drv(`MODE_UP, 1'b1, 1'b0, 6'h00);
    t(3);
    chk("disabled", count_outputs, 6'h3e);
    drv(`MODE_HOLD, 1'b0, 1'b0, 6'h00);
    t(3);
    chk("hold", count_outputs, 6'h3e);
    $display("counting test done");
    drv(`MODE_PRESET, 1'b1, 1'b0, `CNT_ONES);
    t(3);
    chk("terminal load", {count_outputs, carry_out_n, lookahead_carry_out_n}, 8'hff);
    drv(`MODE_HOLD, 1'b0, 1'b0, 6'h00);
    t(1);
    async_clear <= 1'b1;
    #1 chk("clear", {count_outputs, carry_out_n, lookahead_carry_out_n}, 8'h03);
    @(posedge aclk);
    async_clear <= 1'b0;
    t(2);
    chk("after clear", count_outputs, `CNT_ZERO);
    $display("clear test done");
    drv(`MODE_UP, 1'b0, 1'b1, 6'h00);
    wr(`OFF_CTRL, 32'h1);
    chk("freeze resp", resp, `RESP_OKAY);
    rd_reg(`OFF_STATUS);
    held = rd[5:0];
    t(4);
    rd_reg(`OFF_STATUS);
    chk("frozen", rd[5:0], held);
    t(1);
    // two terminal pulses of one cycle each so far: one up, one down
    rd_reg(`OFF_EVENTS);
    chk("events", rd, 32'h00000002);
    wr(`OFF_EVENTS, 32'h0);
    rd_reg(`OFF_EVENTS);
    chk("events cleared", rd, `DATA_ZERO);
    t(1);
    rd_reg(32'h10);
    chk("bad read resp", resp, `RESP_DECERR);
    chk("bad read data", rd, `DATA_ZERO);
    wr(32'h10, 32'h1);
    chk("bad write", resp, `RESP_DECERR);
    t(1);
    wr(`OFF_CTRL, 32'h0);
    held = count_outputs;
    t(1);
    chk("thawed", count_outputs, held + 6'h01);
    $display("register test done");
    drv(`MODE_PRESET, 1'b1, 1'b1, 6'h00);
    t(1);
    drv(`MODE_UP, 1'b1, 1'b1, 6'h00);
    chain <= 1'b1;
    t(200);
    chain <= 1'b0;
    drv(`MODE_HOLD, 1'b1, 1'b1, 6'h00);
    t(2);
    chk("chain", count_outputs, 6'h03);
    $display("cascade test done");
    end_sim;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #20000;
    n_errors = n_errors + 1;
    end_sim;
  end
endmodule

bind six_bit_updown_counter counter_asserts chk_i (.aclk, .aresetn, .async_clear,
  .mode_select_a, .mode_select_b, .carry_enable_n, .lookahead_carry_in_n, .preset_inputs,
  .count_outputs, .carry_out_n, .carry_out, .lookahead_carry_out_n);
